// *** logic/gsm_monitor.sv ***
`timescale 1ns/10ps
// Behaviour
// RULE1 - Frequency out of limits after delay, post-holdoff
// RULE2 - Frequency 12% over high limit stops immediately
// RULE3 - Rpm out of limits after delay, post-holdoff
// RULE4 - Rpm overshoot always stops immediately; code stops only if its i_sd_action bit is set and disable is off
// RULE5 - Phase voltage out of limits for fail time
// RULE6 - Battery voltage out of limits after delay
// RULE7 - Not running after all start attempts
// RULE8 - Charge voltage low after holdoff
// RULE9 - Engine controller silent three seconds raises alarm
// RULE10 - Controller timeout only checked while fuel on
// RULE11 - Voltage deviation from average for fail time
// RULE12 - Current deviation from average, programmable action
// RULE13 - Overcurrent trips on inverse-time accumulated excess
// RULE14 - Overcurrent cleared early cancels pending trip
// RULE15 - Pickup rpm under crank cut for time
// RULE16 - Any expired service counter raises alarm
// RULE17 - Both buttons held five seconds reset counters
// RULE18 - Shutdown lights led, opens contactor, stops engine
// RULE19 - Only the first shutdown fault is registered
// RULE20 - Latched alarms stay after condition clears
// RULE21 - Disable input turns shutdowns into warnings
// RULE22 - Persistence timers restart when condition clears
module gsm_monitor #(
    parameter int unsigned TICK_CYC = gsm_pkg::TICK_CYC,
    parameter int unsigned ECU_TICKS = gsm_pkg::ECU_TIMEOUT_MS,
    parameter int unsigned HOLD_TICKS = gsm_pkg::SRV_HOLD_MS
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Measurements and settings.
    input wire gsm_pkg::gsm_meas_t i_meas,
    input wire gsm_pkg::gsm_limit_t i_limit,
    input wire gsm_pkg::gsm_timer_t i_timer,
    input wire logic [gsm_pkg::N_AL-1:0] i_latch_mask,
    input wire logic [gsm_pkg::N_AL-1:0] i_sd_action,
    // Engine status.
    input wire logic i_engine_running,
    input wire logic i_fuel_on,
    input wire logic i_starts_exhausted,
    input wire logic i_ecu_msg,
    input wire logic [2:0] i_service_expired,
    input wire logic i_alarm_reset,
    // Panel pins.
    input wire logic i_disable_prot_pin,
    input wire logic i_btn_mute_pin,
    input wire logic i_btn_lamp_pin,
    // Shutdown outputs.
    output logic o_shutdown,
    output logic o_alarm_led,
    output logic o_alarm_out,
    output logic o_engine_stop,
    output logic o_gen_contactor_open,
    output logic [gsm_pkg::N_AL-1:0] o_shutdown_bits,
    output logic [gsm_pkg::N_AL-1:0] o_warn_bits,
    // Service counter reset.
    output logic o_service_reset,
    output logic o_service_done_msg
);

    // ----------------------------------------
    // Pin synchronisers and millisecond tick
    // ----------------------------------------
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic dis_s;
    logic both_s;
    logic [31:0] tick_cnt_r;
    logic tick;

    // Two flops on each panel pin.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {i_disable_prot_pin, i_btn_mute_pin, i_btn_lamp_pin};
            sync2_r <= sync1_r;
        end
    end

    assign dis_s = sync2_r[2];
    assign both_s = sync2_r[1] & sync2_r[0];
    assign tick = (tick_cnt_r == TICK_CYC - 1);

    // Free-running divider giving one pulse per millisecond.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            tick_cnt_r <= 32'h0;
        else if (tick)
            tick_cnt_r <= 32'h0;
        else
            tick_cnt_r <= tick_cnt_r + 32'h1;
    end

    // ----------------------------------------
    // Fault holdoff after engine start
    // ----------------------------------------
    logic [15:0] run_ms_r;
    logic holdoff_done;

    // Counts running time; restarts whenever the engine stops.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            run_ms_r <= 16'h0;
        else if (!i_engine_running)
            run_ms_r <= 16'h0;
        else if (tick && run_ms_r != gsm_pkg::CNT_MAX)
            run_ms_r <= run_ms_r + 16'h1;
    end

    assign holdoff_done = i_engine_running && (run_ms_r >= i_timer.holdoff);

    // ----------------------------------------
    // Fault conditions
    // ----------------------------------------
    // True when three times x differs from the phase sum by more than three limits.
    function automatic logic dev3(input logic [15:0] x, input logic [17:0] s,
                                  input logic [15:0] lim);
        logic [17:0] x3;
        logic [17:0] d;
        x3 = 18'(x) * 18'h3;
        d = (x3 > s) ? x3 - s : s - x3;
        return d > 18'(lim) * 18'h3;
    endfunction

    logic [17:0] vsum;
    logic [17:0] isum;
    logic over_f;
    logic over_rpm;
    logic [15:0] imax;
    logic oc_over;
    logic [gsm_pkg::N_CH-1:0] p_cond;
    logic [gsm_pkg::N_CH-1:0] p_trip;
    logic [15:0] p_dly [gsm_pkg::N_CH];
    logic [15:0] p_cnt_r [gsm_pkg::N_CH];

    assign vsum = 18'(i_meas.va) + 18'(i_meas.vb) + 18'(i_meas.vc);
    assign isum = 18'(i_meas.ia) + 18'(i_meas.ib) + 18'(i_meas.ic);
    // Second frequency limit 12% above the high limit, always watched.
    assign over_f = 32'(i_meas.freq) * gsm_pkg::OVERF_DEN >
                    32'(i_limit.freq_hi) * gsm_pkg::OVERF_NUM; // RULE2
    assign over_rpm = i_meas.rpm > i_limit.rpm_over; // RULE4
    assign imax = (i_meas.ia > i_meas.ib) ?
                  ((i_meas.ia > i_meas.ic) ? i_meas.ia : i_meas.ic) :
                  ((i_meas.ib > i_meas.ic) ? i_meas.ib : i_meas.ic);
    assign oc_over = imax > i_limit.oc_lim;

    // Conditions that must persist, each with a delay; CH_VOLT, CH_VUNB and CH_IUNB share volt_fail.
    always_comb
    begin
        p_cond[gsm_pkg::CH_FREQ] = holdoff_done && (i_meas.freq < i_limit.freq_lo ||
                                   i_meas.freq > i_limit.freq_hi); // RULE1
        p_cond[gsm_pkg::CH_RPM] = holdoff_done && (i_meas.rpm < i_limit.rpm_lo ||
                                  i_meas.rpm > i_limit.rpm_hi); // RULE3
        p_cond[gsm_pkg::CH_VOLT] = holdoff_done &&
            (i_meas.va < i_limit.volt_lo || i_meas.va > i_limit.volt_hi ||
             i_meas.vb < i_limit.volt_lo || i_meas.vb > i_limit.volt_hi ||
             i_meas.vc < i_limit.volt_lo || i_meas.vc > i_limit.volt_hi); // RULE5
        p_cond[gsm_pkg::CH_BATT] = i_meas.vbat < i_limit.bat_lo ||
                                   i_meas.vbat > i_limit.bat_hi; // RULE6
        p_cond[gsm_pkg::CH_VUNB] = holdoff_done && (dev3(i_meas.va, vsum, i_limit.unbal) ||
            dev3(i_meas.vb, vsum, i_limit.unbal) ||
            dev3(i_meas.vc, vsum, i_limit.unbal)); // RULE11
        p_cond[gsm_pkg::CH_IUNB] = holdoff_done && (dev3(i_meas.ia, isum, i_limit.unbal) ||
            dev3(i_meas.ib, isum, i_limit.unbal) ||
            dev3(i_meas.ic, isum, i_limit.unbal)); // RULE12
        p_cond[gsm_pkg::CH_PICK] = i_engine_running &&
                                   i_meas.pickup_rpm < i_limit.crank_cut; // RULE15
        p_dly[gsm_pkg::CH_FREQ] = i_timer.freq_dly;
        p_dly[gsm_pkg::CH_RPM] = i_timer.rpm_dly;
        p_dly[gsm_pkg::CH_VOLT] = i_timer.volt_fail;
        p_dly[gsm_pkg::CH_BATT] = i_timer.bat_dly;
        p_dly[gsm_pkg::CH_VUNB] = i_timer.volt_fail;
        p_dly[gsm_pkg::CH_IUNB] = i_timer.volt_fail;
        p_dly[gsm_pkg::CH_PICK] = i_timer.sig_loss;
    end

    // ----------------------------------------
    // Persistence timers
    // ----------------------------------------
    for (genvar g = 0; g < gsm_pkg::N_CH; g++)
    begin : g_persist
        // Counts milliseconds of continuous fault; any gap restarts it.
        always_ff @(posedge i_sys_clk or posedge i_reset)
        begin
            if (i_reset)
                p_cnt_r[g] <= 16'h0;
            else if (!p_cond[g])
                p_cnt_r[g] <= 16'h0; // RULE22
            else if (tick && p_cnt_r[g] != gsm_pkg::CNT_MAX)
                p_cnt_r[g] <= p_cnt_r[g] + 16'h1;
        end
        assign p_trip[g] = p_cond[g] && (p_cnt_r[g] >= p_dly[g]);
    end

    // ----------------------------------------
    // Inverse-time overcurrent
    // ----------------------------------------
    logic [31:0] oc_acc_r;
    logic [32:0] oc_sum;

    assign oc_sum = 33'(oc_acc_r) + 33'(imax - i_limit.oc_lim);

    // Excess over the limit is integrated; larger overloads trip sooner.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            oc_acc_r <= 32'h0;
        else if (!oc_over)
            oc_acc_r <= 32'h0; // RULE14
        else if (tick)
            oc_acc_r <= oc_sum[32] ? 32'hFFFFFFFF : oc_sum[31:0]; // RULE13
    end

    // ----------------------------------------
    // Engine controller message timeout
    // ----------------------------------------
    logic [15:0] ecu_cnt_r;

    // Silence timer; held at zero while fuel is off or on each message.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            ecu_cnt_r <= 16'h0;
        else if (!i_fuel_on || i_ecu_msg)
            ecu_cnt_r <= 16'h0; // RULE10
        else if (tick && ecu_cnt_r != 16'(ECU_TICKS))
            ecu_cnt_r <= ecu_cnt_r + 16'h1; // RULE9
    end

    // ----------------------------------------
    // Alarm vector
    // ----------------------------------------
    logic [gsm_pkg::N_AL-1:0] al;
    logic [gsm_pkg::N_AL-1:0] al_sd;
    logic [gsm_pkg::N_AL-1:0] first;

    always_comb
    begin
        al = '0;
        al[gsm_pkg::AL_FREQ] = p_trip[gsm_pkg::CH_FREQ];
        al[gsm_pkg::AL_OVERFREQ] = over_f;
        al[gsm_pkg::AL_RPM] = p_trip[gsm_pkg::CH_RPM];
        al[gsm_pkg::AL_OVERSPEED] = over_rpm;
        al[gsm_pkg::AL_VOLT] = p_trip[gsm_pkg::CH_VOLT];
        al[gsm_pkg::AL_BATT] = p_trip[gsm_pkg::CH_BATT];
        al[gsm_pkg::AL_START] = i_starts_exhausted && !i_engine_running; // RULE7
        al[gsm_pkg::AL_CHARGE] = holdoff_done &&
                                 i_meas.vcharge < i_limit.charge_lo; // RULE8
        al[gsm_pkg::AL_ECU] = i_fuel_on && ecu_cnt_r == 16'(ECU_TICKS); // RULE9
        al[gsm_pkg::AL_VUNBAL] = p_trip[gsm_pkg::CH_VUNB];
        al[gsm_pkg::AL_IUNBAL] = p_trip[gsm_pkg::CH_IUNB];
        al[gsm_pkg::AL_OVERCUR] = oc_over && oc_acc_r >= i_limit.oc_k; // RULE13
        al[gsm_pkg::AL_PICKUP] = p_trip[gsm_pkg::CH_PICK];
        al[gsm_pkg::AL_SERVICE] = |i_service_expired; // RULE16
    end

    // Only alarms whose action is shutdown compete; lowest bit wins a tie.
    assign al_sd = al & i_sd_action; // RULE12
    assign first = al_sd & (~al_sd + 1'b1);

    // ----------------------------------------
    // First-fault shutdown register
    // ----------------------------------------
    logic [gsm_pkg::N_AL-1:0] sd_r;
    logic [gsm_pkg::N_AL-1:0] warn_r;

    // Captures the first shutdown; later faults are ignored while it stands.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            sd_r <= '0;
        else if (sd_r == '0)
        begin
            if (!dis_s)
                sd_r <= first; // RULE19
        end
        else if ((sd_r & al) == '0 && ((sd_r & i_latch_mask) == '0 || i_alarm_reset))
            sd_r <= '0; // RULE20
    end

    // With protections disabled and no shutdown standing, every alarm is shown as a warning only.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            warn_r <= '0;
        else if (dis_s && sd_r == '0)
            warn_r <= al; // RULE21
        else
            warn_r <= '0;
    end

    // Shutdown drives the led, contactor release, stop and alarm output.
    assign o_shutdown = |sd_r; // RULE18
    assign o_alarm_led = |sd_r;
    assign o_alarm_out = |sd_r;
    assign o_engine_stop = |sd_r;
    assign o_gen_contactor_open = |sd_r;
    assign o_shutdown_bits = sd_r;
    assign o_warn_bits = warn_r;

    // ----------------------------------------
    // Service counter reset by button hold
    // ----------------------------------------
    gsm_pkg::gsm_srv_t srv_r;
    logic [15:0] hold_cnt_r;
    logic srv_pulse_r;

    // Both buttons held for the full time give one reset pulse.
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            srv_r <= gsm_pkg::SRV_IDLE;
            hold_cnt_r <= 16'h0;
            srv_pulse_r <= 1'b0;
        end
        else
        begin
            srv_pulse_r <= 1'b0;
            unique case (srv_r)
                gsm_pkg::SRV_IDLE:
                begin
                    hold_cnt_r <= 16'h0;
                    if (both_s)
                        srv_r <= gsm_pkg::SRV_HOLD;
                end
                gsm_pkg::SRV_HOLD:
                begin
                    if (!both_s)
                        srv_r <= gsm_pkg::SRV_IDLE;
                    else if (tick && hold_cnt_r == 16'(HOLD_TICKS - 1))
                    begin
                        srv_r <= gsm_pkg::SRV_DONE;
                        srv_pulse_r <= 1'b1; // RULE17
                    end
                    else if (tick)
                        hold_cnt_r <= hold_cnt_r + 16'h1;
                end
                gsm_pkg::SRV_DONE:
                begin
                    if (!both_s)
                        srv_r <= gsm_pkg::SRV_IDLE;
                end
            endcase
        end
    end

    assign o_service_reset = srv_pulse_r;
    assign o_service_done_msg = (srv_r == gsm_pkg::SRV_DONE); // RULE17

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    a_overfreq_stop: assert property ((over_f && sd_r == '0 && !dis_s && // RULE2
        i_sd_action[gsm_pkg::AL_OVERFREQ] && al_sd[0] == 1'b0) |=> o_engine_stop)
        else $error("Overfrequency did not stop the engine.");
    a_overspeed_gate: assert property (over_rpm |-> al[gsm_pkg::AL_OVERSPEED]) // RULE4
        else $error("Overspeed alarm missing.");
    a_holdoff_mask: assert property (!holdoff_done |-> !al[gsm_pkg::AL_FREQ] && // RULE1
        !al[gsm_pkg::AL_RPM] && !al[gsm_pkg::AL_VOLT] && !al[gsm_pkg::AL_CHARGE])
        else $error("Alarm raised inside holdoff.");
    a_ecu_fuel_off: assert property (!i_fuel_on |=> ecu_cnt_r == 16'h0) // RULE10
        else $error("Controller timer ran with fuel off.");
    a_first_only: assert property ((sd_r != '0) |=> (sd_r == $past(sd_r) || sd_r == '0)) // RULE19
        else $error("Second shutdown accepted.");
    a_latch_hold: assert property ((|(sd_r & i_latch_mask) && !i_alarm_reset) // RULE20
        |=> sd_r == $past(sd_r))
        else $error("Latched alarm cleared.");
    a_disable_warn: assert property ((dis_s && sd_r == '0) |=> sd_r == '0 && // RULE21
        warn_r == $past(al))
        else $error("Disabled protection still shut down.");
    a_oc_cancel: assert property (!oc_over |=> oc_acc_r == 32'h0 && // RULE14
        ($past(oc_over) || !al[gsm_pkg::AL_OVERCUR]))
        else $error("Overcurrent not cancelled.");
    a_persist_restart: assert property (!p_cond[gsm_pkg::CH_BATT] |=> // RULE22
        p_cnt_r[gsm_pkg::CH_BATT] == 16'h0)
        else $error("Persistence timer not restarted.");
    a_service_pulse: assert property (o_service_reset |=> !o_service_reset && // RULE17
        (o_service_done_msg || !$past(both_s, 1)))
        else $error("Service reset pulse malformed.");

    c_shutdown: cover property (sd_r == '0 ##1 sd_r != '0);
    c_overcur: cover property (al[gsm_pkg::AL_OVERCUR]);
    c_service: cover property (o_service_reset);
    c_disabled: cover property (dis_s && al != '0);

endmodule

// *** logic/gsm_pkg.sv ***
package gsm_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned ECU_TIMEOUT_MS = 3000;
    localparam int unsigned SRV_HOLD_MS = 5000;
    localparam logic [31:0] OVERF_NUM = 32'h70;
    localparam logic [31:0] OVERF_DEN = 32'h64;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // ----------------------------------------
    // Alarm bit positions
    // ----------------------------------------
    localparam int N_AL = 14;
    localparam int AL_FREQ = 0;
    localparam int AL_OVERFREQ = 1;
    localparam int AL_RPM = 2;
    localparam int AL_OVERSPEED = 3;
    localparam int AL_VOLT = 4;
    localparam int AL_BATT = 5;
    localparam int AL_START = 6;
    localparam int AL_CHARGE = 7;
    localparam int AL_ECU = 8;
    localparam int AL_VUNBAL = 9;
    localparam int AL_IUNBAL = 10;
    localparam int AL_OVERCUR = 11;
    localparam int AL_PICKUP = 12;
    localparam int AL_SERVICE = 13;

    // Persistence channel positions.
    localparam int N_CH = 7;
    localparam int CH_FREQ = 0;
    localparam int CH_RPM = 1;
    localparam int CH_VOLT = 2;
    localparam int CH_BATT = 3;
    localparam int CH_VUNB = 4;
    localparam int CH_IUNB = 5;
    localparam int CH_PICK = 6;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] rpm;
        logic [15:0] pickup_rpm;
        logic [15:0] va;
        logic [15:0] vb;
        logic [15:0] vc;
        logic [15:0] ia;
        logic [15:0] ib;
        logic [15:0] ic;
        logic [15:0] vbat;
        logic [15:0] vcharge;
    } gsm_meas_t;

    typedef struct packed {
        logic [15:0] freq_lo;
        logic [15:0] freq_hi;
        logic [15:0] rpm_lo;
        logic [15:0] rpm_hi;
        logic [15:0] rpm_over;
        logic [15:0] volt_lo;
        logic [15:0] volt_hi;
        logic [15:0] bat_lo;
        logic [15:0] bat_hi;
        logic [15:0] charge_lo;
        logic [15:0] unbal;
        logic [15:0] oc_lim;
        logic [15:0] crank_cut;
        logic [31:0] oc_k;
    } gsm_limit_t;

    // All delays in milliseconds.
    typedef struct packed {
        logic [15:0] holdoff;
        logic [15:0] freq_dly;
        logic [15:0] rpm_dly;
        logic [15:0] volt_fail;
        logic [15:0] bat_dly;
        logic [15:0] sig_loss;
    } gsm_timer_t;

    typedef enum logic [1:0] {SRV_IDLE, SRV_HOLD, SRV_DONE} gsm_srv_t;

endpackage

// *** sim/gsm_engine_model.sv ***
`timescale 1ns/10ps
module gsm_engine_model (
    // Clock.
    input wire logic i_sys_clk,
    // Scenario controls.
    input wire logic i_ecu_en,
    input wire logic i_press,
    // Far-side signals.
    output logic o_ecu_msg = 1'b0,
    output logic o_btn_mute_pin,
    output logic o_btn_lamp_pin
);
    logic [2:0] gap_r = 3'h0;

    // The engine controller talks every eight cycles, well inside the silence limit.
    always_ff @(posedge i_sys_clk)
    begin
        gap_r <= gap_r + 3'h1;
        o_ecu_msg <= i_ecu_en && (gap_r == 3'h7);
    end

    // The operator presses both panel buttons together.
    assign o_btn_mute_pin = i_press;
    assign o_btn_lamp_pin = i_press;
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
    logic i_sys_clk;
    logic i_reset;
    gsm_pkg::gsm_meas_t meas;
    gsm_pkg::gsm_limit_t lim;
    gsm_pkg::gsm_timer_t tmr;
    logic [gsm_pkg::N_AL-1:0] latch_mask;
    logic [gsm_pkg::N_AL-1:0] sd_bits;
    logic [gsm_pkg::N_AL-1:0] warn_bits;
    logic [gsm_pkg::N_AL-1:0] act;
    logic [2:0] srv_exp;
    logic running, fuel, exhausted, ecu_msg, alarm_reset, dis_pin, mute_pin, lamp_pin;
    logic press, ecu_en, shutdown, led, aout, estop, cont_open, srv_reset, srv_msg;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int n;

    // Far side and the block under test.
    gsm_engine_model model (.i_sys_clk(i_sys_clk), .i_ecu_en(ecu_en), .i_press(press),
        .o_ecu_msg(ecu_msg), .o_btn_mute_pin(mute_pin), .o_btn_lamp_pin(lamp_pin));
    gsm_monitor #(.TICK_CYC(4), .ECU_TICKS(5), .HOLD_TICKS(6)) dut (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_meas(meas), .i_limit(lim),
        .i_timer(tmr), .i_latch_mask(latch_mask), .i_sd_action(act),
        .i_engine_running(running), .i_fuel_on(fuel), .i_starts_exhausted(exhausted),
        .i_ecu_msg(ecu_msg), .i_service_expired(srv_exp), .i_alarm_reset(alarm_reset),
        .i_disable_prot_pin(dis_pin), .i_btn_mute_pin(mute_pin), .i_btn_lamp_pin(lamp_pin),
        .o_shutdown(shutdown), .o_alarm_led(led), .o_alarm_out(aout), .o_engine_stop(estop),
        .o_gen_contactor_open(cont_open), .o_shutdown_bits(sd_bits), .o_warn_bits(warn_bits),
        .o_service_reset(srv_reset), .o_service_done_msg(srv_msg));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    // The 250 MHz system clock.
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    // A hung run is cut short and counted as a mismatch.
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    // Compares one value with its expectation.
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Reports the counts and ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Resets the block for 8 cycles and restores healthy inputs.
    task automatic do_reset();
        if ($time > 0)
            @(posedge i_sys_clk);
        i_reset <= 1'b1;
        meas <= '{16'h1F4, 16'h5DC, 16'h5DC, 16'hE6, 16'hE6, 16'hE6,
                  16'h64, 16'h64, 16'h64, 16'h18, 16'h1A};
        lim <= '{16'h1C2, 16'h226, 16'h514, 16'h6A4, 16'h708, 16'hC8, 16'h104,
                 16'h14, 16'h1E, 16'h14, 16'h32, 16'hC8, 16'h258, 32'hFA};
        tmr <= '{16'h2, 16'h2, 16'h2, 16'h2, 16'h3, 16'h3};
        {running, fuel, exhausted, alarm_reset, dis_pin, press} <= 6'h00;
        ecu_en <= 1'b1;
        latch_mask <= '0;
        act <= '1;
        srv_exp <= 3'h0;
        repeat (8) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    // Watches one alarm bit for n cycles and checks whether it rose.
    task automatic expect_sd(input int b, input int cyc, input logic exp);
        logic hit;
        hit = 1'b0;
        repeat (cyc)
        begin
            @(negedge i_sys_clk);
            if (sd_bits[b] === 1'b1)
                hit = 1'b1;
        end
        check("alarm bit", {15'h0, hit}, {15'h0, exp});
    endtask

    // Drives or removes the fault of a timed channel.
    task automatic set_fault(input int b, input logic on);
        @(posedge i_sys_clk);
        if (b == gsm_pkg::AL_BATT)
            meas.vbat <= on ? 16'h0F : 16'h18;
        else
            meas.ia <= on ? 16'h12C : 16'h64;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        do_reset();
        // Overspeed and failed start together: lowest bit wins, later alarms are refused.
        @(posedge i_sys_clk);
        meas.rpm <= 16'h76C;
        exhausted <= 1'b1;
        repeat (3) @(negedge i_sys_clk);
        check("stop outputs", {11'h0, shutdown, led, aout, estop, cont_open}, 16'h1F);
        @(posedge i_sys_clk);
        srv_exp <= 3'h1;
        repeat (3) @(negedge i_sys_clk);
        check("first alarm", {2'h0, sd_bits}, 16'h0008);
        // Plain and latched overspeed after the condition goes away.
        for (int l = 0; l < 2; l++)
        begin
            do_reset();
            latch_mask <= l ? 14'h0008 : 14'h0000;
            expect_sd(gsm_pkg::AL_OVERSPEED, 2, 1'b0);
            @(posedge i_sys_clk);
            meas.rpm <= 16'h76C;
            expect_sd(gsm_pkg::AL_OVERSPEED, 3, 1'b1);
            @(posedge i_sys_clk);
            meas.rpm <= 16'h5DC;
            repeat (4) @(negedge i_sys_clk);
            check("after clear", {2'h0, sd_bits}, l ? 16'h0008 : 16'h0000);
            @(posedge i_sys_clk);
            alarm_reset <= 1'b1;
            repeat (3) @(negedge i_sys_clk);
            check("after reset", {2'h0, sd_bits}, 16'h0000);
        end
        // Second frequency limit at exactly 12 % above the high limit.
        do_reset();
        meas.freq <= 16'h268;
        expect_sd(gsm_pkg::AL_OVERFREQ, 20, 1'b0);
        @(posedge i_sys_clk);
        meas.freq <= 16'h269;
        expect_sd(gsm_pkg::AL_OVERFREQ, 3, 1'b1);
        // Low frequency waits for holdoff and delay once running.
        do_reset();
        running <= 1'b1;
        meas.freq <= 16'h190;
        expect_sd(gsm_pkg::AL_FREQ, 4, 1'b0);
        expect_sd(gsm_pkg::AL_FREQ, 40, 1'b1);
        // Battery and overcurrent: an interrupted fault restarts its timing.
        for (int k = 0; k < 2; k++)
        begin
            n = k ? gsm_pkg::AL_OVERCUR : gsm_pkg::AL_BATT;
            do_reset();
            set_fault(n, 1'b1);
            expect_sd(n, 7, 1'b0);
            set_fault(n, 1'b0);
            set_fault(n, 1'b1);
            expect_sd(n, 7, 1'b0);
            expect_sd(n, 20, 1'b1);
        end
        // Engine controller silence with fuel on, and with fuel off.
        do_reset();
        fuel <= 1'b1;
        expect_sd(gsm_pkg::AL_ECU, 40, 1'b0);
        @(posedge i_sys_clk);
        ecu_en <= 1'b0;
        expect_sd(gsm_pkg::AL_ECU, 40, 1'b1);
        do_reset();
        ecu_en <= 1'b0;
        expect_sd(gsm_pkg::AL_ECU, 40, 1'b0);
        // Failed start and expired service counter.
        do_reset();
        exhausted <= 1'b1;
        expect_sd(gsm_pkg::AL_START, 3, 1'b1);
        do_reset();
        srv_exp <= 3'h4;
        expect_sd(gsm_pkg::AL_SERVICE, 3, 1'b1);
        // Protections disabled: overspeed becomes a warning only.
        do_reset();
        dis_pin <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        meas.rpm <= 16'h76C;
        repeat (4) @(negedge i_sys_clk);
        check("shutdown", {15'h0, shutdown}, 16'h0000);
        check("warning", {15'h0, warn_bits[gsm_pkg::AL_OVERSPEED]}, 16'h0001);
        // An alarm whose action is not shutdown never stops the engine.
        do_reset();
        act[gsm_pkg::AL_OVERSPEED] <= 1'b0;
        @(posedge i_sys_clk);
        meas.rpm <= 16'h76C;
        expect_sd(gsm_pkg::AL_OVERSPEED, 6, 1'b0);
        check("no action stop", {15'h0, estop}, 16'h0000);
        // Both buttons held for the hold time reset the service counters.
        do_reset();
        press <= 1'b1;
        n = 0;
        while (srv_reset !== 1'b1 && n < 60)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        check("service pulse", {15'h0, srv_reset}, 16'h0001);
        check("service early", {15'h0, n >= 16}, 16'h0001);
        check("done message", {15'h0, srv_msg}, 16'h0001);
        @(posedge i_sys_clk);
        press <= 1'b0;
        repeat (5) @(negedge i_sys_clk);
        check("message off", {15'h0, srv_msg}, 16'h0000);
        finish_test();
    end
endmodule
